// ==== hw/drx_fifo.sv ====
/*
   Synchronous FIFO with valid/ready on both sides.
   Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module drx_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Storage array
   logic [AW:0] wr_ptr_r; // Write pointer with wrap bit
   logic [AW:0] rd_ptr_r; // Read pointer with wrap bit
   logic push; // Word accepted
   logic pop; // Word delivered

   // Full when pointers differ only in the wrap bit
   assign in_ready_o = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
   assign out_valid_o = wr_ptr_r != rd_ptr_r;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr_r[AW-1:0]];

   // Storage write, no reset needed on data
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end

   // Pointer advance
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule // drx_fifo

// ==== hw/drx_pin_ctrl.sv ====
/*
   Pin-mode and clock-select logic of the audio receiver: strap sensing,
   control port detection and framing, input multiplexer, recovered clock
   routing, clock ratio measurement and the serial audio output.
   Assumes a 100 MHz system clock, the control serial clock as a second
   domain, and an analog front end that delivers the PLL clock and lock.
*/
`timescale 1ns/1ps
module drx_pin_ctrl (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ctrl_serial_clk_i,
   input wire logic addr_strap_0_i,
   input wire logic addr_strap_1_i,
   input wire logic addr_strap_2_i,
   output logic ctrl_serial_out_o,
   output logic ctrl_serial_out_oe_o,
   input wire logic [7:0] biphase_pos_inputs_i,
   output logic biphase_rx_o,
   output logic biphase_aux_o,
   input wire logic pll_mclk_i,
   input wire logic pll_locked_i,
   input wire logic ext_system_clk_i,
   output logic pll_rate_half_o,
   output logic recovered_master_clk_o,
   output logic recovered_master_clk_oe_o,
   output logic rclk_on_ext_o,
   input wire logic sample_valid_i,
   input wire logic [drx_pkg::SAMPLE_W-1:0] sample_data_i,
   output logic sample_ready_o,
   output logic audio_bit_clk_o,
   output logic audio_word_clk_o,
   input wire logic audio_serial_out_i,
   output logic audio_serial_out_o,
   output logic audio_serial_out_oe_o,
   output logic sw_mode_o,
   output logic spi_mode_o,
   output logic [6:0] i2c_addr_o,
   output logic power_down_o
);
   // Pin sync vector bit positions
   localparam int P_CS = 0;
   localparam int P_AD1 = 1;
   localparam int P_AD2 = 2;
   localparam int P_SDO = 3;
   localparam int P_LOCK = 4;
   localparam int P_EXT = 5;
   localparam int P_MCK = 6;

   // ---------------- link domain ----------------
   logic frame_rst_n; // Frame cleared while deselected
   logic [4:0] bit_cnt_r; // Bits taken this frame
   logic [7:0] shift_r; // Incoming bits
   logic [7:0] cmd_r; // Read flag and register index
   logic [7:0] clk_cfg_r; // clock_output_config
   logic [7:0] in_cfg_r; // input_select_config
   logic [7:0] ratio_l_r; // clock_ratio_status copy
   logic [7:0] rd_byte; // Addressed register value
   logic ctrl_out_r; // Read data bit on falling edge
   logic wr_hit; // Data byte completes a write
   logic lmode_s1_r; // SPI mode sync, first stage
   logic lmode_s2_r; // SPI mode sync, second stage
   logic lreq_s1_r; // Ratio request sync, first stage
   logic lreq_s2_r; // Ratio request sync, second stage
   logic lseen_r; // Last request taken, acts as ack

   // ---------------- system domain ----------------
   logic [6:0] pin_s1_r; // Pin sync first stage
   logic [6:0] pin_s2_r; // Pin sync second stage
   logic [6:0] pin_s3_r; // Delayed copy for edges
   logic [15:0] cfg_s1_r; // Config sync first stage
   logic [15:0] cfg_s2_r; // Config sync second stage
   drx_pkg::drx_cfg_t cfg; // Config in this domain
   logic [1:0] boot_cnt_r; // Settle count after release
   logic taken_r; // Straps captured
   drx_pkg::drx_strap_t strap_r; // Captured strap levels
   logic spi_mode_r; // Control port in SPI mode
   logic ext_sel_r; // External clock on output
   logic [4:0] win_cnt_r; // Recovered clock periods
   logic [7:0] ext_cnt_r; // External clock periods
   logic [7:0] ratio_hold_r; // Value offered to link
   logic req_tog_r; // Ratio request toggle
   logic ack_s1_r; // Ack sync first stage
   logic ack_s2_r; // Ack sync second stage
   logic mck_rise; // Recovered clock edge seen
   logic ext_rise; // External clock edge seen
   logic [2:0] bdiv_r; // Bit clock divider
   logic bclk_r; // Bit clock level
   logic wclk_r; // Word clock level
   logic [4:0] slot_r; // Bit slot within channel
   logic [31:0] sh_r; // Output shift register
   logic launch; // Output data advance edge
   logic fifo_valid; // Sample waiting
   logic [drx_pkg::SAMPLE_W-1:0] fifo_data; // Next sample
   logic fifo_pop; // Sample taken for a channel

   // Frame logic only runs while chip select is low
   assign frame_rst_n = rst_n_i & ~addr_strap_0_i;

   // Bit intake on the control clock rising edge
   always_ff @(posedge ctrl_serial_clk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt_r <= 5'h00;
         shift_r <= 8'h00;
         cmd_r <= 8'h00;
      end else if (bit_cnt_r != drx_pkg::FRAME_DONE) begin
         // Extra bits past the data byte are ignored
         bit_cnt_r <= bit_cnt_r + 5'h01;
         shift_r <= {shift_r[6:0], addr_strap_1_i};
         if (bit_cnt_r == drx_pkg::CMD_LAST) begin
            cmd_r <= {shift_r[6:0], addr_strap_1_i};
         end
      end
   end

   // Write completes on the last data bit of a write frame
   assign wr_hit = lmode_s2_r && !cmd_r[7] && frame_rst_n
                   && bit_cnt_r == drx_pkg::FRAME_LAST;

   // Control registers, cleared only by reset
   always_ff @(posedge ctrl_serial_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_cfg_r <= drx_pkg::CLK_CFG_RST;
         in_cfg_r <= drx_pkg::IN_CFG_RST;
      end else if (wr_hit) begin
         if (cmd_r[6:0] == drx_pkg::REG_CLK_CFG) begin
            clk_cfg_r <= {shift_r[6:0], addr_strap_1_i};
         end else if (cmd_r[6:0] == drx_pkg::REG_IN_CFG) begin
            in_cfg_r <= {shift_r[6:0], addr_strap_1_i};
         end
      end
   end

   // Read decode, unmapped indices read zero
   always_comb begin
      if (cmd_r[6:0] == drx_pkg::REG_CLK_CFG) begin
         rd_byte = clk_cfg_r;
      end else if (cmd_r[6:0] == drx_pkg::REG_IN_CFG) begin
         rd_byte = in_cfg_r;
      end else if (cmd_r[6:0] == drx_pkg::REG_RATIO) begin
         rd_byte = ratio_l_r;
      end else begin
         rd_byte = 8'h00;
      end
   end

   // Read data launched on the falling edge, MSB first
   always_ff @(negedge ctrl_serial_clk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         ctrl_out_r <= 1'b0;
      end else if (cmd_r[7] && bit_cnt_r[4:3] == 2'b01) begin
         ctrl_out_r <= rd_byte[~bit_cnt_r[2:0]];
      end else begin
         ctrl_out_r <= 1'b0;
      end
   end

   // SPI mode level into the link domain
   always_ff @(posedge ctrl_serial_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lmode_s1_r <= 1'b0;
         lmode_s2_r <= 1'b0;
      end else begin
         lmode_s1_r <= spi_mode_r;
         lmode_s2_r <= lmode_s1_r;
      end
   end

   // Ratio handshake, link side: take held word on a new toggle
   always_ff @(posedge ctrl_serial_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lreq_s1_r <= 1'b0;
         lreq_s2_r <= 1'b0;
         lseen_r <= 1'b0;
         ratio_l_r <= drx_pkg::RATIO_RST;
      end else begin
         lreq_s1_r <= req_tog_r;
         lreq_s2_r <= lreq_s1_r;
         if (lreq_s2_r != lseen_r) begin
            lseen_r <= lreq_s2_r;
            ratio_l_r <= ratio_hold_r;
         end
      end
   end

   // Read data drives only in SPI mode while selected
   assign ctrl_serial_out_o = ctrl_out_r;
   assign ctrl_serial_out_oe_o = spi_mode_r & ~addr_strap_0_i;

   // Pin synchronisers with one delay stage for edges
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_r <= 7'h00;
         pin_s2_r <= 7'h00;
         pin_s3_r <= 7'h00;
      end else begin
         pin_s1_r <= {pll_mclk_i, ext_system_clk_i, pll_locked_i,
                      audio_serial_out_i, addr_strap_2_i,
                      addr_strap_1_i, addr_strap_0_i};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // Quasi-static configuration into the system domain
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_s1_r <= {drx_pkg::CLK_CFG_RST, drx_pkg::IN_CFG_RST};
         cfg_s2_r <= {drx_pkg::CLK_CFG_RST, drx_pkg::IN_CFG_RST};
      end else begin
         cfg_s1_r <= {clk_cfg_r, in_cfg_r};
         cfg_s2_r <= cfg_s1_r;
      end
   end
   assign cfg = drx_pkg::drx_cfg_t'(cfg_s2_r);

   // Strap capture after the synchronisers settle
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_cnt_r <= 2'h0;
         taken_r <= 1'b0;
         strap_r <= '0;
      end else if (!taken_r) begin
         boot_cnt_r <= boot_cnt_r + 2'h1;
         if (boot_cnt_r == drx_pkg::BOOT_LAST) begin
            taken_r <= 1'b1;
            strap_r.sw_mode <= pin_s2_r[P_SDO];
            strap_r.addr <= {pin_s2_r[P_AD2], pin_s2_r[P_AD1],
                             pin_s2_r[P_CS]};
         end
      end
   end

   // Chip-select falling edge latches SPI mode until reset
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spi_mode_r <= 1'b0;
      end else if (taken_r && pin_s3_r[P_CS] && !pin_s2_r[P_CS]) begin
         spi_mode_r <= 1'b1;
      end
   end

   assign sw_mode_o = strap_r.sw_mode;
   assign spi_mode_o = spi_mode_r;
   assign i2c_addr_o = {drx_pkg::I2C_ADDR_HI, strap_r.addr};
   assign power_down_o = ~taken_r;

   // Input multiplexer, two outputs from eight inputs
   assign biphase_rx_o =
      biphase_pos_inputs_i[cfg.in_cfg[drx_pkg::RX_SEL_LSB +: 3]];
   assign biphase_aux_o =
      biphase_pos_inputs_i[cfg.in_cfg[drx_pkg::AUX_SEL_LSB +: 3]];

   // Switchover selection from enable and lock
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_sel_r <= 1'b0;
      end else begin
         ext_sel_r <= cfg.clk_cfg[drx_pkg::CLK_SW_BIT]
                      & ~pin_s2_r[P_LOCK];
      end
   end

   // Output clock source; a glitch-free cell takes this in silicon
   assign recovered_master_clk_o = ext_sel_r ? ext_system_clk_i
                                             : pll_mclk_i;
   assign recovered_master_clk_oe_o =
      taken_r & ~cfg.in_cfg[drx_pkg::RCLK_DIS_BIT];
   assign rclk_on_ext_o = ext_sel_r;
   // PLL output divider: 256x by default, 128x when set
   assign pll_rate_half_o = cfg.clk_cfg[drx_pkg::RATE_BIT];

   assign mck_rise = pin_s2_r[P_MCK] & ~pin_s3_r[P_MCK];
   assign ext_rise = pin_s2_r[P_EXT] & ~pin_s3_r[P_EXT];

   // External edges counted over a fixed recovered-clock window
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_cnt_r <= 5'h00;
         ext_cnt_r <= 8'h00;
         ratio_hold_r <= drx_pkg::RATIO_RST;
         req_tog_r <= 1'b0;
      end else begin
         if (mck_rise && win_cnt_r == drx_pkg::RATIO_WIN_LAST) begin
            win_cnt_r <= 5'h00;
            ext_cnt_r <= 8'h00;
            // Offer a new value only when the last was taken
            if (req_tog_r == ack_s2_r) begin
               ratio_hold_r <= ext_cnt_r;
               req_tog_r <= ~req_tog_r;
            end
         end else begin
            if (mck_rise) begin
               win_cnt_r <= win_cnt_r + 5'h01;
            end
            if (ext_rise && ext_cnt_r != 8'hff) begin
               ext_cnt_r <= ext_cnt_r + 8'h01;
            end
         end
      end
   end

   // Ack back from the link domain
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= lseen_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // Sample buffer between decoder and serial port
   drx_fifo #(
      .WIDTH(drx_pkg::SAMPLE_W),
      .DEPTH(drx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(sample_valid_i),
      .in_data_i(sample_data_i),
      .in_ready_o(sample_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(fifo_pop)
   );

   // Bit clock divider, runs once straps are taken
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bdiv_r <= 3'h0;
         bclk_r <= 1'b0;
      end else if (taken_r) begin
         if (bdiv_r == drx_pkg::BCLK_HALF_LAST) begin
            bdiv_r <= 3'h0;
            bclk_r <= ~bclk_r;
         end else begin
            bdiv_r <= bdiv_r + 3'h1;
         end
      end
   end

   // Launch on the chosen bit clock edge
   assign launch = taken_r && bdiv_r == drx_pkg::BCLK_HALF_LAST
                   && (bclk_r == ~cfg.clk_cfg[drx_pkg::BCLK_EDGE_BIT]);
   assign fifo_pop = launch && slot_r == drx_pkg::SLOT_LAST && fifo_valid;

   // Channel slots: word clock flips every 32 bits
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slot_r <= drx_pkg::SLOT_LAST;
         wclk_r <= 1'b1;
         sh_r <= 32'h0000_0000;
      end else if (launch) begin
         if (slot_r == drx_pkg::SLOT_LAST) begin
            slot_r <= 5'h00;
            wclk_r <= ~wclk_r;
            // Underrun sends a silent channel
            if (fifo_valid) begin
               sh_r <= {fifo_data, 8'h00};
            end else begin
               sh_r <= 32'h0000_0000;
            end
         end else begin
            slot_r <= slot_r + 5'h01;
            sh_r <= {sh_r[30:0], 1'b0};
         end
      end
   end

   assign audio_bit_clk_o = bclk_r;
   assign audio_word_clk_o = wclk_r;
   assign audio_serial_out_o = sh_r[31];
   // Pin stays released during reset so the pull-up can be sensed
   assign audio_serial_out_oe_o = taken_r;
endmodule // drx_pin_ctrl

// ==== hw/drx_pkg.sv ====
/*
   Package of the receiver pin-mode and clock-select block: register
   indices, field positions, reset values, frame and audio timing counts
   and the packed carrier types.
   Assumes nothing of its surroundings.
*/
package drx_pkg;
   // Register indices on the control port
   localparam logic [6:0] REG_CLK_CFG = 7'h01;
   localparam logic [6:0] REG_IN_CFG = 7'h04;
   localparam logic [6:0] REG_RATIO = 7'h18;
   // clock_output_config fields
   localparam int CLK_SW_BIT = 7;
   localparam int BCLK_EDGE_BIT = 2;
   localparam int RATE_BIT = 1;
   // input_select_config fields
   localparam int RCLK_DIS_BIT = 7;
   localparam int AUX_SEL_LSB = 3;
   localparam int RX_SEL_LSB = 0;
   // Reset values
   localparam logic [7:0] CLK_CFG_RST = 8'h00;
   localparam logic [7:0] IN_CFG_RST = 8'h00;
   localparam logic [7:0] RATIO_RST = 8'h00;
   // Control frame: command byte then data byte
   localparam logic [4:0] CMD_LAST = 5'h07;
   localparam logic [4:0] FRAME_LAST = 5'h0f;
   localparam logic [4:0] FRAME_DONE = 5'h10;
   // Upper bus address bits; value is arbitrary
   localparam logic [3:0] I2C_ADDR_HI = 4'h2;
   // Strap settle cycles after reset release
   localparam logic [1:0] BOOT_LAST = 2'h3;
   // Audio port
   localparam int SAMPLE_W = 24;
   localparam int FIFO_DEPTH = 32;
   localparam logic [4:0] SLOT_LAST = 5'h1f;
   localparam logic [2:0] BCLK_HALF_LAST = 3'h3;
   // Ratio window in recovered clock periods, ratio in 4.4 format
   localparam logic [4:0] RATIO_WIN_LAST = 5'h0f;
   // Configuration as it crosses into the system domain
   typedef struct packed {
      logic [7:0] clk_cfg;
      logic [7:0] in_cfg;
   } drx_cfg_t;
   // Levels caught at reset release
   typedef struct packed {
      logic sw_mode;
      logic [2:0] addr;
   } drx_strap_t;
endpackage

// ==== tb/drx_host_model.sv ====
/*
   Control port host: makes the link clock inside frames and as stray clocks while deselected, drives
   chip select and data in, collects read data.
   Assumes the device launches read bits on the falling link edge.
*/
`timescale 1ns/1ps
module drx_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   input wire logic dout_i
);
   // Idle: link clock still, not selected
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end
   // Command byte then data byte, MSB first, 48 ns link period
   task automatic frame(input logic rd, input logic [6:0] idx, input logic [7:0] wd,
                        output logic [7:0] rdat);
      logic [15:0] sh;
      sh = {rd, idx, wd};
      rdat = 8'h00;
      #7 cs_n_o = 1'b0;
      for (int i = 0; i < 16; i++) begin
         din_o = sh[15-i];
         #24;
         // Read bit settled since the last falling edge
         if (i >= 8) rdat[15-i] = dout_i;
         sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      // Released data line shows no stale bit
      din_o = ~din_o;
      // Gap between frames; no channel status access, so speed is free
      #48;
   endtask
   // Stray link clocks while not selected
   task automatic stray(input int n);
      repeat (n) begin
         din_o = ~din_o;
         #24 sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
      end
   endtask
endmodule // drx_host_model

// ==== tb/drx_pin_ctrl_asserts.sv ====
/*
   Port checker of the pin-control block.
   Bound into drx_pin_ctrl; sees only its ports.
*/
`timescale 1ns/1ps
module drx_pin_ctrl_asserts (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic addr_strap_0_i,
   input wire logic addr_strap_1_i,
   input wire logic addr_strap_2_i,
   input wire logic ext_system_clk_i,
   input wire logic pll_mclk_i,
   input wire logic recovered_master_clk_o,
   input wire logic rclk_on_ext_o,
   input wire logic ctrl_serial_out_oe_o,
   input wire logic spi_mode_o,
   input wire logic audio_bit_clk_o,
   input wire logic audio_word_clk_o,
   input wire logic sw_mode_o,
   input wire logic [6:0] i2c_addr_o,
   input wire logic power_down_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic wclk_r; // Word clock one cycle back
   logic seen_r; // A word clock edge was seen
   logic [8:0] wcnt_r; // Cycles since that edge
   logic wlvl_r; // Bit clock level at the last word edge
   // Word clock half-period counter; a launch edge change shifts it half a bit clock period
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wclk_r <= 1'b1;
         seen_r <= 1'b0;
         wcnt_r <= 9'h000;
         wlvl_r <= 1'b0;
      end else begin
         wclk_r <= audio_word_clk_o;
         if (audio_word_clk_o != wclk_r) begin
            wlvl_r <= audio_bit_clk_o;
         end
         seen_r <= seen_r | (audio_word_clk_o != wclk_r);
         wcnt_r <= (audio_word_clk_o != wclk_r) ? 9'h000 : wcnt_r + 9'h001;
      end
   end
   a_pd_after_rel: assert property ($rose(rst_n_i) |-> power_down_o [*3])
      else $error("power down left too early");
   a_rclk_on_ext: assert property (rclk_on_ext_o |-> recovered_master_clk_o == ext_system_clk_i)
      else $error("recovered clock not the external clock");
   a_rclk_on_pll: assert property (!rclk_on_ext_o |-> recovered_master_clk_o == pll_mclk_i)
      else $error("recovered clock not the pll clock");
   a_bit_clk_half: assert property ($rose(audio_bit_clk_o) |->
      audio_bit_clk_o [*4] ##1 !audio_bit_clk_o [*4])
      else $error("bit clock period wrong");
   a_word_clk_half: assert property (seen_r && audio_word_clk_o != wclk_r
      && audio_bit_clk_o == wlvl_r |-> wcnt_r == 9'h0ff)
      else $error("word clock half period wrong");
   a_ctrl_out_en: assert property (ctrl_serial_out_oe_o == (spi_mode_o && !addr_strap_0_i))
      else $error("control out enable wrong");
   a_spi_sticky: assert property (spi_mode_o |=> spi_mode_o)
      else $error("spi mode dropped");
   a_strap_capture: assert property ($fell(power_down_o) |-> i2c_addr_o[2:0] ==
      $past({addr_strap_2_i, addr_strap_1_i, addr_strap_0_i}))
      else $error("address straps not captured");
   a_strap_held: assert property (!power_down_o && !$past(power_down_o) |->
      $stable(i2c_addr_o) && $stable(sw_mode_o))
      else $error("strap selections changed");
   c_switch: cover property ($rose(rclk_on_ext_o));
   c_spi: cover property ($rose(spi_mode_o));
   c_boot: cover property ($fell(power_down_o));
endmodule // drx_pin_ctrl_asserts
bind drx_pin_ctrl drx_pin_ctrl_asserts chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .addr_strap_0_i(addr_strap_0_i), .addr_strap_1_i(addr_strap_1_i),
   .addr_strap_2_i(addr_strap_2_i), .ext_system_clk_i(ext_system_clk_i),
   .pll_mclk_i(pll_mclk_i), .recovered_master_clk_o(recovered_master_clk_o),
   .rclk_on_ext_o(rclk_on_ext_o), .ctrl_serial_out_oe_o(ctrl_serial_out_oe_o),
   .spi_mode_o(spi_mode_o), .audio_bit_clk_o(audio_bit_clk_o),
   .audio_word_clk_o(audio_word_clk_o), .sw_mode_o(sw_mode_o),
   .i2c_addr_o(i2c_addr_o), .power_down_o(power_down_o));

// ==== tb/drx_pin_ctrl_bench.sv ====
/*
   Self-checking bench of the pin-control block.
   Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module drx_pin_ctrl_bench;
   logic clock_i = 1'b0, rst_n_i = 1'b0, pll_mclk = 1'b0, ext_clk = 1'b0, locked = 1'b1;
   logic strap2 = 1'b0, s_valid = 1'b0, cap_lvl = 1'b1, bclk_q, aout_q;
   logic [7:0] rx_in = 8'h00, v;
   logic [23:0] s_data = 24'h00_0000;
   logic c_out, c_oe, rx_o, aux_o, rate_half, rclk, rclk_oe, on_ext, s_ready;
   logic bclk, wclk, aout, aout_oe, sw_mode, spi_mode, pd;
   logic [6:0] i2c_addr;
   wire logic sclk, cs_n, din_w, dout_w, sdo_pin;
   int mismatches = 0, checks = 0, cyc = 0, seed = 32'h4107, n, bad, tog;
   // Pull-ups on the shared data pins
   assign dout_w = c_oe ? c_out : 1'b1;
   assign sdo_pin = aout_oe ? aout : 1'b1;
   always #5 clock_i = ~clock_i;
   always #40 pll_mclk = ~pll_mclk;
   always #20 ext_clk = ~ext_clk;
   drx_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din_w), .dout_i(dout_w));
   drx_pin_ctrl dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_serial_clk_i(sclk),
      .addr_strap_0_i(cs_n), .addr_strap_1_i(din_w), .addr_strap_2_i(strap2),
      .ctrl_serial_out_o(c_out), .ctrl_serial_out_oe_o(c_oe), .biphase_pos_inputs_i(rx_in),
      .biphase_rx_o(rx_o), .biphase_aux_o(aux_o), .pll_mclk_i(pll_mclk),
      .pll_locked_i(locked), .ext_system_clk_i(ext_clk), .pll_rate_half_o(rate_half),
      .recovered_master_clk_o(rclk), .recovered_master_clk_oe_o(rclk_oe),
      .rclk_on_ext_o(on_ext), .sample_valid_i(s_valid), .sample_data_i(s_data),
      .sample_ready_o(s_ready), .audio_bit_clk_o(bclk), .audio_word_clk_o(wclk),
      .audio_serial_out_i(sdo_pin), .audio_serial_out_o(aout), .audio_serial_out_oe_o(aout_oe),
      .sw_mode_o(sw_mode), .spi_mode_o(spi_mode), .i2c_addr_o(i2c_addr), .power_down_o(pd));
   // Serial data must not move at the capture edge of the bit clock
   always @(negedge clock_i) begin
      if (bclk !== bclk_q && bclk === cap_lvl && aout !== aout_q) bad++;
      if (aout !== aout_q) tog++;
      bclk_q = bclk;
      aout_q = aout;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] x;
      host.frame(1'b0, a, d, x);
      repeat (4) @(negedge clock_i);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      host.frame(1'b1, a, 8'h00, d);
      @(negedge clock_i);
   endtask
   // Reset held until clocks run, then strap capture
   task automatic do_reset;
      rst_n_i = 1'b0;
      repeat (3) @(negedge clock_i);
      `CHK("power_down", 1'b1, pd)
      `CHK("rate_half", 1'b0, rate_half)
      rst_n_i = 1'b1;
      repeat (8) @(negedge clock_i);
   endtask
   initial begin
      strap2 = 1'($random(seed));
      do_reset();
      `CHK("sw_mode", 1'b1, sw_mode)
      `CHK("i2c_addr", {drx_pkg::I2C_ADDR_HI, strap2, 1'b0, 1'b1}, i2c_addr)
      `CHK("spi_mode", 1'b0, spi_mode)
      rd(drx_pkg::REG_CLK_CFG, v);
      `CHK("spi_mode", 1'b1, spi_mode)
      `CHK("i2c_addr", {drx_pkg::I2C_ADDR_HI, strap2, 1'b0, 1'b1}, i2c_addr)
      wr(7'h33, 8'h5a);
      rd(7'h33, v);
      `CHK("unmapped", 8'h00, v)
      rd(drx_pkg::REG_CLK_CFG, v);
      `CHK("clk_cfg", drx_pkg::CLK_CFG_RST, v)
      rd(drx_pkg::REG_RATIO, v);
      rd(drx_pkg::REG_RATIO, v);
      `CHK("ratio", 8'h20, v)
      wr(drx_pkg::REG_RATIO, 8'hff);
      rd(drx_pkg::REG_RATIO, v);
      `CHK("ratio ro", 8'h20, v)
      for (int s = 0; s < 8; s++) begin
         wr(drx_pkg::REG_IN_CFG, {2'b00, 3'(7 - s), 3'(s)});
         rd(drx_pkg::REG_IN_CFG, v);
         `CHK("in_cfg", {2'b00, 3'(7 - s), 3'(s)}, v)
         repeat (3) begin
            rx_in = 8'($random(seed));
            @(negedge clock_i);
            `CHK("rx", rx_in[s], rx_o)
            `CHK("aux", rx_in[7-s], aux_o)
         end
      end
      host.stray(9);
      rd(drx_pkg::REG_IN_CFG, v);
      `CHK("in_cfg stray", 8'h07, v)
      `CHK("rclk_oe", 1'b1, rclk_oe)
      wr(drx_pkg::REG_IN_CFG, 8'h80);
      `CHK("rclk_oe", 1'b0, rclk_oe)
      wr(drx_pkg::REG_CLK_CFG, 8'h02);
      `CHK("rate_half", 1'b1, rate_half)
      wr(drx_pkg::REG_CLK_CFG, 8'h00);
      `CHK("rate_half", 1'b0, rate_half)
      locked = 1'b0;
      repeat (8) @(negedge clock_i);
      `CHK("on_ext off", 1'b0, on_ext)
      locked = 1'b1;
      wr(drx_pkg::REG_CLK_CFG, 8'h80);
      `CHK("on_ext locked", 1'b0, on_ext)
      locked = 1'b0;
      repeat (8) @(negedge clock_i);
      `CHK("on_ext", 1'b1, on_ext)
      locked = 1'b1;
      s_valid = 1'b1;
      n = 0;
      while (s_ready === 1'b1 && n < 40) begin
         s_data = 24'($random(seed));
         @(negedge clock_i);
         n++;
      end
      s_valid = 1'b0;
      `CHK("fifo fill", 1'b1, n >= 32 && n <= 33)
      for (int e = 0; e < 2; e++) begin
         wr(drx_pkg::REG_CLK_CFG, {5'h00, 1'(e), 2'b00});
         cap_lvl = ~1'(e);
         bad = 0;
         tog = 0;
         repeat (4500) @(negedge clock_i);
         `CHK("capture edge moves", 0, bad)
         `CHK("data toggles", 1'b1, tog > 0)
      end
      wr(drx_pkg::REG_CLK_CFG, 8'h02);
      do_reset();
      test_done();
   end
endmodule // drx_pin_ctrl_bench
